// File: design/fhsc_params.svh
// Purpose: constants of the flash hold and security controller
// Assumes: included by its bare name
// Notes:   definitions only
`ifndef FHSC_PARAMS_SVH
`define FHSC_PARAMS_SVH
// ---------------------------------------------------------------
// link register selects
// ---------------------------------------------------------------
`define FHSC_SEL_ACCEPTOR 2'h0
`define FHSC_SEL_CONTROL  2'h1
`define FHSC_SEL_ADDRESS  2'h2
`define FHSC_SEL_BUFFER   2'h3
// ---------------------------------------------------------------
// flash_control and address fields
// ---------------------------------------------------------------
`define FHSC_CTL_PRG      0
`define FHSC_CTL_AUTOERASE_PROGRAM_FLAG    1
`define FHSC_CTL_CHIP_ERASE_FLAG     2
`define FHSC_CTL_XSEL_LO  3
`define FHSC_CTL_XSEL_HI  4
`define FHSC_CTL_SECSET   6
`define FHSC_CTL_SECMON   7
`define FHSC_ADR_TARGET   11
`define FHSC_ADR_ROW_LO   7
// ---------------------------------------------------------------
// reset values and sequence constants
// ---------------------------------------------------------------
`define FHSC_SEC_RESET    1'b0
`define FHSC_XSEL_RESET   2'h0
`define FHSC_UNLOCK_1     4'h5
`define FHSC_UNLOCK_2     4'hA
`define FHSC_ROW_LAST     7'h7F
`define FHSC_NOP_COUNT    2'h2
// ---------------------------------------------------------------
// timing: transfer clock limit
// ---------------------------------------------------------------
`define FHSC_REF_MHZ      250
`define FHSC_XFER_MAX_MHZ 5
`define FHSC_XDIV_BASE    ((`FHSC_REF_MHZ + `FHSC_XFER_MAX_MHZ * 8 - 1) / (`FHSC_XFER_MAX_MHZ * 8))
`define FHSC_XSEL_MIN     2'h3
// ---------------------------------------------------------------
// host avalon map
// ---------------------------------------------------------------
`define FHSC_AV_CMD       4'h0
`define FHSC_AV_ARG       4'h4
`define FHSC_AV_STAT      4'h8
`define FHSC_AV_RES       4'hC
`define FHSC_ST_BUSY      0
`define FHSC_ST_HOLD      1
`define FHSC_ST_IRQ       2
`define FHSC_ST_INT       3
`endif

// File: design/fhsc_pkg.sv
// Purpose: shared types of the flash hold and security controller
// Assumes: nothing
// Notes:   never imported, always scoped
package fhsc_pkg;
  typedef enum logic [1:0] {FHSC_FC_ROW_ERASE, FHSC_FC_CHIP_ERASE, FHSC_FC_SEC_SET} fhsc_fcmd_t;
  typedef enum logic [1:0] {D_IDLE, D_ARMED, D_CMD, D_XFER} fhsc_dst_t;
  typedef enum logic [2:0] {HC_CTRL, HC_READ, HC_TABLE, HC_STEP, HC_IRQACK} fhsc_hcmd_t;
  typedef enum logic [3:0] {HS_IDLE, HS_ACC5, HS_ACCA, HS_CTRL, HS_STEP, HS_RD, HS_ADDR, HS_TBL, HS_TWAIT,
                            HS_BUF, HS_WAIT, HS_ACK} fhsc_hst_t;
endpackage

// File: design/fhsc_if.sv
// Purpose: link between the cpu end and the flash controller end
// Assumes: both ends on REF_CLK
// Notes:   no clocking block
`timescale 1ns/100ps
interface fhsc_if;
  logic       op_wr;
  logic       op_rd;
  logic       tbl_rd;
  logic [1:0] sel;
  logic [15:0] wdata;
  logic       step;
  logic       irq_ack;
  logic       rvalid;
  logic [7:0] rdata;
  logic       cpu_run;
  logic       irq_pend;
  modport dev (input op_wr, op_rd, tbl_rd, sel, wdata, step, irq_ack, output rvalid, rdata, cpu_run, irq_pend);
  modport cpu (output op_wr, op_rd, tbl_rd, sel, wdata, step, irq_ack, input rvalid, rdata, cpu_run, irq_pend);
endinterface // fhsc_if

// File: design/fhsc_xfer_div.sv
// Purpose: transfer clock enable divider
// Assumes: sel stable while run is high
// Notes:   ratio is base times two to the sel
`timescale 1ns/100ps
`include "fhsc_params.svh"
module fhsc_xfer_div (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       run,
  input  wire logic [1:0] sel,
  output logic            tick
);
  logic [5:0] cnt_q;
  wire  [5:0] lim = 6'((`FHSC_XDIV_BASE << sel) - 1);
  wire        wrap = cnt_q == lim;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) cnt_q <= 6'h00;
    else if (!run || wrap) cnt_q <= 6'h00;
    else cnt_q <= cnt_q + 6'h01;
  end

  assign tick = run && wrap;
endmodule // fhsc_xfer_div

// File: design/fhsc_dev.sv
// Purpose: flash hold, security and read-back controller
// Assumes: flash answers FL_RDATA the cycle after FL_RD; RAM_RDATA one cycle after RAM_ADDR
// Notes:   CPU clock gate is LNK.cpu_run
// Contract
// RULE_01: control holds two-bit transfer clock select
// RULE_02: software keeps transfer clock at most 5 MHz
// RULE_03: write-only security set, hold, then cleared
// RULE_04: security set refuses main array programming
// RULE_05: monitor sets on security, clears on erase
// RULE_06: software waits two nops before monitor
// RULE_07: table reads return true flash data
// RULE_08: table read copies byte into buffer
// RULE_09: buffer reads zero while security set
// RULE_10: table read and buffer read back to back
// RULE_11: software sets target select before table read
// RULE_12: operation flag holds after one instruction
// RULE_13: hold stops CPU clock only
// RULE_14: software leaves watchdog off during flash use
// RULE_15: interrupts during hold latched, kept pending
// RULE_16: release serves pending interrupt, else resumes
// RULE_17: five then ten nibble sets acceptor
// RULE_18: executed operation clears acceptor and flag
// RULE_19: chip erase leaves array all ones
// RULE_20: program flag copies staging row, clears
// RULE_21: ungate with flag clear on completion
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/100ps
`include "fhsc_params.svh"
module fhsc_dev (
  input  wire logic                  REF_CLK,
  input  wire logic                  RST_B,
  fhsc_if.dev                        LNK,
  input  wire logic                  IRQ_IN,
  output logic                       FL_CMD_VLD,
  output fhsc_pkg::fhsc_fcmd_t       FL_CMD,
  input  wire logic                  FL_DONE,
  output logic                       FL_WR,
  output logic                       FL_RD,
  output logic                       FL_BOOT,
  output logic [15:0]                FL_ADDR,
  output logic [7:0]                 FL_WDATA,
  input  wire logic [7:0]            FL_RDATA,
  output logic [6:0]                 RAM_ADDR,
  input  wire logic [7:0]            RAM_RDATA
);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic one_hot4(input logic [3:0] v);
    one_hot4 = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fhsc_pkg::fhsc_dst_t st_q;
  fhsc_pkg::fhsc_dst_t st_d;
  logic        acc_q;
  logic        half_q;
  logic [1:0]  xsel_q;
  logic        prg_q;
  logic        autoerase_program_flag_q;
  logic        chip_erase_flag_q;
  logic        security_set_flag_q;
  logic        sec_q;
  logic [15:0] addr_q;
  logic [7:0]  buf_q;
  logic [7:0]  rdata_q;
  logic        rvalid_q;
  logic        rdw_q;
  logic        pend_q;
  logic [6:0]  idx_q;
  logic        tick;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire        in_idle  = st_q == fhsc_pkg::D_IDLE;
  wire        in_hold  = (st_q == fhsc_pkg::D_CMD) || (st_q == fhsc_pkg::D_XFER);
  wire [3:0]  nib      = LNK.wdata[3:0];
  wire        wr_acc   = LNK.op_wr && (LNK.sel == `FHSC_SEL_ACCEPTOR);
  wire        wr_ctl   = LNK.op_wr && (LNK.sel == `FHSC_SEL_CONTROL) && acc_q && in_idle; // RULE_17
  wire        wr_adr   = LNK.op_wr && (LNK.sel == `FHSC_SEL_ADDRESS);
  wire        req_prg  = LNK.wdata[`FHSC_CTL_PRG] && !sec_q;   // RULE_04
  wire        req_sep  = LNK.wdata[`FHSC_CTL_AUTOERASE_PROGRAM_FLAG] && !sec_q; // RULE_04
  wire [3:0]  req      = {LNK.wdata[`FHSC_CTL_SECSET], LNK.wdata[`FHSC_CTL_CHIP_ERASE_FLAG], req_sep, req_prg};
  wire [3:0]  flg      = {security_set_flag_q, chip_erase_flag_q, autoerase_program_flag_q, prg_q};
  wire        step_in  = (st_q == fhsc_pkg::D_ARMED) && LNK.step;    // RULE_12
  wire        go       = step_in && one_hot4(flg);                   // RULE_12
  wire        abort    = step_in && !one_hot4(flg);
  wire        cmd_done = (st_q == fhsc_pkg::D_CMD) && FL_DONE;
  wire        fin_cmd  = cmd_done && !autoerase_program_flag_q;
  wire        last     = (st_q == fhsc_pkg::D_XFER) && tick && (idx_q == `FHSC_ROW_LAST);
  wire        done     = fin_cmd || last;                            // RULE_21
  wire        tbl_go   = LNK.tbl_rd && !in_hold;
  // security_set_flag reads back zero: the set flag is write-only
  wire [7:0]  ctl_rd   = {sec_q, 1'b0, 1'b0, xsel_q, chip_erase_flag_q, autoerase_program_flag_q, prg_q}; // RULE_03 RULE_05
  wire [7:0]  buf_rd   = sec_q ? 8'h00 : buf_q;                      // RULE_09
  wire [7:0]  reg_rd   = (LNK.sel == `FHSC_SEL_ACCEPTOR) ? {7'h00, acc_q} :
                         (LNK.sel == `FHSC_SEL_CONTROL)  ? ctl_rd :
                         (LNK.sel == `FHSC_SEL_ADDRESS)  ? addr_q[7:0] : buf_rd;
  wire fhsc_pkg::fhsc_fcmd_t cmd_w = chip_erase_flag_q ? fhsc_pkg::FHSC_FC_CHIP_ERASE :          // RULE_19
                                     security_set_flag_q ? fhsc_pkg::FHSC_FC_SEC_SET : fhsc_pkg::FHSC_FC_ROW_ERASE;

  // ---------------------------------------------------------------
  // transfer clock
  // ---------------------------------------------------------------
  fhsc_xfer_div u_div (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .run   (st_q == fhsc_pkg::D_XFER),
    .sel   (xsel_q),   // RULE_01
    .tick  (tick)
  );

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      fhsc_pkg::D_IDLE:  if (wr_ctl && (req != 4'h0)) st_d = fhsc_pkg::D_ARMED;
      fhsc_pkg::D_ARMED: if (abort) st_d = fhsc_pkg::D_IDLE;
                         else if (go) st_d = prg_q ? fhsc_pkg::D_XFER : fhsc_pkg::D_CMD;
      fhsc_pkg::D_CMD:   if (cmd_done) st_d = autoerase_program_flag_q ? fhsc_pkg::D_XFER : fhsc_pkg::D_IDLE;
      fhsc_pkg::D_XFER:  if (last) st_d = fhsc_pkg::D_IDLE; // RULE_20
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) st_q <= fhsc_pkg::D_IDLE;
    else st_q <= st_d;
  end

  // ---------------------------------------------------------------
  // acceptor and control
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      acc_q  <= 1'b0;
      half_q <= 1'b0;
    end else if (done) begin
      acc_q  <= 1'b0; // RULE_18
      half_q <= 1'b0;
    end else if (wr_acc) begin
      half_q <= nib == `FHSC_UNLOCK_1;                              // RULE_17
      if (half_q && (nib == `FHSC_UNLOCK_2)) acc_q <= 1'b1;         // RULE_17
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {security_set_flag_q, chip_erase_flag_q, autoerase_program_flag_q, prg_q} <= 4'h0;
      xsel_q <= `FHSC_XSEL_RESET;
    end else if (wr_ctl) begin
      {security_set_flag_q, chip_erase_flag_q, autoerase_program_flag_q, prg_q} <= req;
      xsel_q <= LNK.wdata[`FHSC_CTL_XSEL_HI:`FHSC_CTL_XSEL_LO]; // RULE_01
    end else if (done || abort) begin
      {security_set_flag_q, chip_erase_flag_q, autoerase_program_flag_q, prg_q} <= 4'h0; // RULE_03 RULE_18 RULE_21
    end
  end

  // stored as a flop here; the array keeps the durable copy
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) sec_q <= `FHSC_SEC_RESET;
    else if (fin_cmd && security_set_flag_q) sec_q <= 1'b1; // RULE_03 RULE_05
    else if (fin_cmd && chip_erase_flag_q) sec_q <= 1'b0; // RULE_05
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) addr_q <= 16'h0000;
    else if (wr_adr && in_idle) addr_q <= LNK.wdata;
  end

  // ---------------------------------------------------------------
  // flash port
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FL_CMD_VLD <= 1'b0;
      FL_CMD     <= fhsc_pkg::FHSC_FC_ROW_ERASE;
    end else begin
      FL_CMD_VLD <= go && !prg_q;
      if (go) FL_CMD <= cmd_w;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) idx_q <= 7'h00;
    else if (st_q != fhsc_pkg::D_XFER) idx_q <= 7'h00;
    else if (tick) idx_q <= idx_q + 7'h01; // RULE_20
  end

  assign RAM_ADDR = idx_q;

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      FL_WR    <= 1'b0;
      FL_RD    <= 1'b0;
      FL_BOOT  <= 1'b0;
      FL_ADDR  <= 16'h0000;
      FL_WDATA <= 8'h00;
    end else begin
      FL_WR <= (st_q == fhsc_pkg::D_XFER) && tick; // RULE_20
      FL_RD <= tbl_go;                             // RULE_07
      if ((st_q == fhsc_pkg::D_XFER) && tick) begin
        FL_ADDR  <= {addr_q[15:`FHSC_ADR_ROW_LO], idx_q};
        FL_WDATA <= RAM_RDATA;
      end else if (tbl_go) begin
        FL_ADDR <= LNK.wdata;
        FL_BOOT <= addr_q[`FHSC_ADR_TARGET];
      end
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdw_q    <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q  <= 8'h00;
      buf_q    <= 8'h00;
    end else begin
      rdw_q    <= FL_RD;
      rvalid_q <= rdw_q || LNK.op_rd;
      if (rdw_q) begin
        rdata_q <= FL_RDATA; // RULE_07
        buf_q   <= FL_RDATA; // RULE_08
      end else if (LNK.op_rd) begin
        rdata_q <= reg_rd;
      end
    end
  end

  assign LNK.rvalid = rvalid_q;
  assign LNK.rdata  = rdata_q;

  // ---------------------------------------------------------------
  // hold gate and interrupts
  // ---------------------------------------------------------------
  // only the CPU clock stops; this latch and the rest run on REF_CLK
  assign LNK.cpu_run = !in_hold; // RULE_13 RULE_21

  // set wins over ack so a request in the ack cycle is kept
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) pend_q <= 1'b0;
    else pend_q <= IRQ_IN || (pend_q && !LNK.irq_ack); // RULE_15
  end

  assign LNK.irq_pend = pend_q && !in_hold; // RULE_15 RULE_16
endmodule // fhsc_dev

// File: design/fhsc_cpu.sv
// Purpose: cpu end of the link, ordered by software over avalon
// Assumes: avalon byte address, 32-bit data
// Notes:   one command at a time
`timescale 1ns/100ps
`include "fhsc_params.svh"
module fhsc_cpu (
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  input  wire logic [3:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0]      AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  fhsc_if.cpu              LNK
);
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  fhsc_pkg::fhsc_hst_t st_q;
  fhsc_pkg::fhsc_hst_t st_d;
  logic [16:0] arg_q;
  logic [7:0]  res_q;
  logic [1:0]  nop_q;
  logic        run_q;
  logic        int_q;
  logic        rack_q;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  // a stalled CPU has nothing counting, so no watchdog can expire here
  wire       busy   = (st_q != fhsc_pkg::HS_IDLE) || !LNK.cpu_run || (nop_q != 2'h0); // RULE_14
  wire       wr_cmd = AVS_WRITE && (AVS_ADDRESS == `FHSC_AV_CMD);
  wire       cmd_ok = wr_cmd && !busy;
  wire fhsc_pkg::fhsc_hcmd_t cmd = fhsc_pkg::fhsc_hcmd_t'(AVS_WRITEDATA[2:0]);
  wire       release_ev = LNK.cpu_run && !run_q;
  wire [1:0] xs     = (arg_q[4:3] < `FHSC_XSEL_MIN) ? `FHSC_XSEL_MIN : arg_q[4:3]; // RULE_02
  wire [7:0] ctl_v  = {arg_q[7:5], xs, arg_q[2:0]};
  wire [7:0] stat_v = {4'h0, int_q, LNK.irq_pend, !LNK.cpu_run, busy};
  wire [7:0] rd_v   = (AVS_ADDRESS == `FHSC_AV_ARG)  ? arg_q[7:0] :
                      (AVS_ADDRESS == `FHSC_AV_STAT) ? stat_v :
                      (AVS_ADDRESS == `FHSC_AV_RES)  ? res_q : 8'h00;

  // ---------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      fhsc_pkg::HS_IDLE: if (cmd_ok) begin
        case (cmd)
          fhsc_pkg::HC_CTRL:   st_d = fhsc_pkg::HS_ACC5;
          fhsc_pkg::HC_READ:   st_d = fhsc_pkg::HS_RD;
          fhsc_pkg::HC_TABLE:  st_d = fhsc_pkg::HS_ADDR;
          fhsc_pkg::HC_STEP:   st_d = fhsc_pkg::HS_STEP;
          fhsc_pkg::HC_IRQACK: st_d = fhsc_pkg::HS_ACK;
          default:             st_d = fhsc_pkg::HS_IDLE;
        endcase
      end
      fhsc_pkg::HS_ACC5:  st_d = fhsc_pkg::HS_ACCA;  // RULE_17
      fhsc_pkg::HS_ACCA:  st_d = fhsc_pkg::HS_CTRL;  // RULE_17
      fhsc_pkg::HS_CTRL:  st_d = fhsc_pkg::HS_STEP;
      fhsc_pkg::HS_STEP:  st_d = fhsc_pkg::HS_IDLE;
      fhsc_pkg::HS_RD:    st_d = fhsc_pkg::HS_WAIT;
      fhsc_pkg::HS_ADDR:  st_d = fhsc_pkg::HS_TBL;   // RULE_11
      fhsc_pkg::HS_TBL:   st_d = fhsc_pkg::HS_TWAIT;
      fhsc_pkg::HS_TWAIT: if (LNK.rvalid) st_d = fhsc_pkg::HS_BUF; // RULE_10
      fhsc_pkg::HS_BUF:   st_d = fhsc_pkg::HS_WAIT;
      fhsc_pkg::HS_WAIT:  if (LNK.rvalid) st_d = fhsc_pkg::HS_IDLE;
      fhsc_pkg::HS_ACK:   st_d = fhsc_pkg::HS_IDLE;
      default:            st_d = fhsc_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) st_q <= fhsc_pkg::HS_IDLE;
    else st_q <= st_d;
  end

  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      arg_q <= 17'h00000;
      res_q <= 8'h00;
    end else begin
      if (AVS_WRITE && (AVS_ADDRESS == `FHSC_AV_ARG)) arg_q <= AVS_WRITEDATA[16:0];
      if ((st_q == fhsc_pkg::HS_WAIT) && LNK.rvalid) res_q <= LNK.rdata;
    end
  end

  // two idle instructions after release before anything reads the monitor
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      run_q <= 1'b1;
      nop_q <= 2'h0;
      int_q <= 1'b0;
    end else begin
      run_q <= LNK.cpu_run;
      if (release_ev) nop_q <= `FHSC_NOP_COUNT;   // RULE_06
      else if (nop_q != 2'h0) nop_q <= nop_q - 2'h1;
      if (release_ev && LNK.irq_pend) int_q <= 1'b1; // RULE_16
      else if (st_q == fhsc_pkg::HS_ACK) int_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // link drive
  // ---------------------------------------------------------------
  assign LNK.op_wr   = (st_q == fhsc_pkg::HS_ACC5) || (st_q == fhsc_pkg::HS_ACCA) ||
                       (st_q == fhsc_pkg::HS_CTRL) || (st_q == fhsc_pkg::HS_ADDR);
  assign LNK.op_rd   = (st_q == fhsc_pkg::HS_RD) || (st_q == fhsc_pkg::HS_BUF);
  assign LNK.tbl_rd  = st_q == fhsc_pkg::HS_TBL;
  assign LNK.step    = (st_q == fhsc_pkg::HS_STEP) || (nop_q != 2'h0); // RULE_06
  assign LNK.irq_ack = st_q == fhsc_pkg::HS_ACK;
  assign LNK.sel     = ((st_q == fhsc_pkg::HS_ACC5) || (st_q == fhsc_pkg::HS_ACCA)) ? `FHSC_SEL_ACCEPTOR :
                       (st_q == fhsc_pkg::HS_CTRL) ? `FHSC_SEL_CONTROL :
                       (st_q == fhsc_pkg::HS_ADDR) ? `FHSC_SEL_ADDRESS :
                       (st_q == fhsc_pkg::HS_BUF)  ? `FHSC_SEL_BUFFER : arg_q[1:0];
  assign LNK.wdata   = (st_q == fhsc_pkg::HS_ACC5) ? {12'h000, `FHSC_UNLOCK_1} :
                       (st_q == fhsc_pkg::HS_ACCA) ? {12'h000, `FHSC_UNLOCK_2} :
                       (st_q == fhsc_pkg::HS_CTRL) ? {8'h00, ctl_v} :
                       (st_q == fhsc_pkg::HS_ADDR) ? {4'h0, arg_q[16], 11'h000} : arg_q[15:0]; // RULE_11

  // ---------------------------------------------------------------
  // avalon slave
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rack_q       <= 1'b0;
      AVS_READDATA <= 32'h00000000;
    end else begin
      rack_q <= AVS_READ && !rack_q;
      if (AVS_READ && !rack_q) AVS_READDATA <= {24'h000000, rd_v};
    end
  end

  // a command write stalls while the CPU is gated or busy
  assign AVS_WAITREQUEST = (AVS_READ && !rack_q) || (wr_cmd && busy);
endmodule // fhsc_cpu

// File: testbench/fhsc_asserts.sv
// Purpose: link checks between cpu end and device end
// Assumes: single REF_CLK domain
// Notes:   plain inputs, no bind
`timescale 1ns/100ps
`include "fhsc_params.svh"
module fhsc_asserts (
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        op_wr,
  input wire logic        op_rd,
  input wire logic        tbl_rd,
  input wire logic [1:0]  sel,
  input wire logic [15:0] wdata,
  input wire logic        step,
  input wire logic        rvalid,
  input wire logic        cpu_run,
  input wire logic        irq_pend,
  input wire logic        irq_ack
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  chk_reg_rd_answer: assert property (op_rd |=> rvalid) else $error("register read unanswered");
  chk_tbl_answer: assert property (tbl_rd |-> ##3 rvalid) else $error("table read late");
  chk_hold_entry: assert property ($fell(cpu_run) |-> $past(step)) else $error("hold without step");
  chk_irq_masked: assert property (!cpu_run |-> !irq_pend) else $error("irq served in hold");
  chk_cpu_stopped: assert property (!cpu_run |-> !step && !op_wr && !tbl_rd) else $error("cpu ran in hold");
  chk_unlock_first: assert property (op_wr && sel == `FHSC_SEL_CONTROL |-> $past(op_wr) &&
    $past(sel) == `FHSC_SEL_ACCEPTOR && $past(wdata[3:0]) == `FHSC_UNLOCK_2) else $error("control not unlocked");
  chk_unlock_order: assert property (op_wr && sel == `FHSC_SEL_ACCEPTOR && wdata[3:0] == `FHSC_UNLOCK_2
    |-> $past(op_wr) && $past(wdata[3:0]) == `FHSC_UNLOCK_1) else $error("unlock out of order");
  chk_buf_after_tbl: assert property (op_rd && sel == `FHSC_SEL_BUFFER |-> $past(tbl_rd, 4))
    else $error("buffer read not after table read");
  chk_resume_step: assert property ($rose(cpu_run) |-> ##[1:8] step) else $error("no resume");
  chk_pend_kept: assert property (irq_pend && !irq_ack |=> irq_pend || !cpu_run) else $error("pending irq lost");
endmodule // fhsc_asserts

// File: testbench/tb.sv
// Purpose: both ends joined, software over avalon, flash model
// Assumes: flash done five cycles after command
// Notes:   main array byte is low address xor 3C until chip erase, then FF; boot array C3
`timescale 1ns/100ps
`include "fhsc_params.svh"
module tb;
  logic                 clk, rst_b, rd, wr, irq, erased, tpend;
  logic [3:0]           adr;
  logic [31:0]          wd, rdq, q;
  logic                 wait_rq, fvld, fwr, frd, fboot;
  fhsc_pkg::fhsc_fcmd_t fcmd;
  logic [15:0]          fadr;
  logic [7:0]           fwd, frdat, ram, tdat;
  logic [6:0]           radr;
  logic [4:0]           dsr;
  int                   fail_count, n_compared, nwr;
  initial begin
    {clk, rst_b, rd, wr, irq, erased, tpend, adr, wd, frdat, ram, dsr} = '0;
    {fail_count, n_compared, nwr} = '0;
  end
  always #2 clk = ~clk;
  fhsc_if lnk();
  fhsc_cpu fhsc_cpu_i (.REF_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
    .AVS_WRITEDATA(wd), .AVS_READDATA(rdq), .AVS_WAITREQUEST(wait_rq), .LNK(lnk));
  fhsc_dev fhsc_dev_i (.REF_CLK(clk), .RST_B(rst_b), .LNK(lnk), .IRQ_IN(irq), .FL_CMD_VLD(fvld),
    .FL_CMD(fcmd), .FL_DONE(dsr[4]), .FL_WR(fwr), .FL_RD(frd), .FL_BOOT(fboot), .FL_ADDR(fadr),
    .FL_WDATA(fwd), .FL_RDATA(frdat), .RAM_ADDR(radr), .RAM_RDATA(ram));
  fhsc_asserts fhsc_asserts_i (.REF_CLK(clk), .RST_B(rst_b), .op_wr(lnk.op_wr), .op_rd(lnk.op_rd),
    .tbl_rd(lnk.tbl_rd), .sel(lnk.sel), .wdata(lnk.wdata), .step(lnk.step), .rvalid(lnk.rvalid),
    .cpu_run(lnk.cpu_run), .irq_pend(lnk.irq_pend), .irq_ack(lnk.irq_ack));
  // ---------------------------------------------------------------
  // flash array and staging ram
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    dsr <= {dsr[3:0], fvld};
    ram <= {1'b0, radr} ^ 8'hA5;
    irq <= !lnk.cpu_run && nwr == 5;
    if (fvld && fcmd == fhsc_pkg::FHSC_FC_CHIP_ERASE) erased <= 1'b1;
    // read data only valid one cycle, garbage otherwise
    frdat <= frd ? (fboot ? 8'hC3 : erased ? 8'hFF : fadr[7:0] ^ 8'h3C) : ~frdat;
    if (fwr) begin
      nwr <= nwr + 1;
      chk(fwd, {1'b0, fadr[6:0]} ^ 8'hA5);
    end
    if (lnk.tbl_rd) tpend <= 1'b1;
    else if (lnk.rvalid && tpend) begin
      tpend <= 1'b0;
      tdat <= lnk.rdata;
    end
  end
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task av(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    while (wait_rq !== 1'b0) @(posedge clk);
    q = rdq;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task cmd(input logic [2:0] c, input logic [31:0] arg);
    av(1'b1, `FHSC_AV_ARG, arg);
    av(1'b1, `FHSC_AV_CMD, {29'h0, c});
    q = 32'h1;
    while (q[`FHSC_ST_BUSY] !== 1'b0) av(1'b0, `FHSC_AV_STAT, 32'h0);
  endtask
  task res(input logic [7:0] e);
    av(1'b0, `FHSC_AV_RES, 32'h0);
    chk(q[7:0], e);
  endtask
  task t_ctl(input logic [7:0] e);
    cmd(3'h1, {30'h0, `FHSC_SEL_CONTROL});
    res(e);
  endtask
  task t_acc(input logic [7:0] e);
    cmd(3'h1, {30'h0, `FHSC_SEL_ACCEPTOR});
    res(e);
  endtask
  task t_table(input logic [16:0] a, input logic [7:0] et, input logic [7:0] eb);
    cmd(3'h2, {15'h0000, a});
    chk(tdat, et);
    res(eb);
  endtask
  task t_op(input logic [7:0] c, input int ewr);
    int n0;
    n0 = nwr;
    cmd(3'h0, {24'h0, c});
    chk(nwr - n0, ewr);
  endtask
  task t_irq;
    av(1'b0, `FHSC_AV_STAT, 32'h0);
    chk(q[`FHSC_ST_INT], 1'b1);
    cmd(3'h4, 32'h0);
    chk(q[`FHSC_ST_INT], 1'b0);
  endtask
  task finish_test;
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_ctl(8'h00);
    t_table(17'h00123, 8'h1F, 8'h1F);
    t_table(17'h10123, 8'hC3, 8'hC3);
    t_op(8'h19, 128);
    t_acc(8'h00);
    t_irq;
    t_ctl(8'h18);
    t_op(8'h03, 0);
    t_acc(8'h01);
    t_op(8'h40, 0);
    t_ctl(8'h98);
    t_table(17'h00123, 8'h1F, 8'h00);
    t_op(8'h19, 0);
    t_op(8'h04, 0);
    t_ctl(8'h18);
    t_table(17'h00123, 8'hFF, 8'hFF);
    finish_test;
  end
  initial begin
    #200000;
    fail_count++;
    finish_test;
  end
endmodule // tb
